// File: rtl/dcc_params.svh
`ifndef DCC_PARAMS_SVH
`define DCC_PARAMS_SVH

// Register byte offsets on the bus
`define DCC_OFS_CMP_ONE 8'h00
`define DCC_OFS_CMP_TWO 8'h04
`define DCC_OFS_IRQ_EN 8'h08
`define DCC_OFS_EVT_STATUS 8'h0c
`define DCC_OFS_EVT_MASK 8'h10
`define DCC_OFS_SETTLE 8'h14

// Comparator control register fields
`define DCC_CTRL_FLAG_BIT 0
`define DCC_CTRL_RESULT_BIT 1
`define DCC_CTRL_PIN_BIT 2
`define DCC_CTRL_NEG_BIT 3
`define DCC_CTRL_POS_BIT 4
`define DCC_CTRL_EN_BIT 5

// Interrupt enable register fields
`define DCC_IEN_CMP_ONE_BIT 0
`define DCC_IEN_CMP_TWO_BIT 1
`define DCC_IEN_GLOBAL_BIT 7

// Event status and mask fields
`define DCC_EVT_CHANGE_LSB 0
`define DCC_EVT_SETTLED_LSB 2

// Reset values
`define DCC_CTRL_RESET 8'h00
`define DCC_IEN_RESET 8'h00
`define DCC_EVT_RESET 4'h0

// Timing
`define DCC_CLK_MHZ 25
`define DCC_SETTLE_NS 10000
`define DCC_SETTLE_CYC ((`DCC_SETTLE_NS * `DCC_CLK_MHZ + 999) / 1000)

`endif

// File: rtl/dcc_pkg.sv
package dcc_pkg;

	// Control register image, bit 7 first
	typedef struct packed {
		logic [1:0] reserved;
		logic enable;
		logic positive_input_select;
		logic negative_input_select;
		logic result_pin_drive_enable;
		logic result;
		logic result_change_flag;
	} dcc_ctrl_t;

	// Steering towards one analog stage
	typedef struct packed {
		logic enable;
		logic positive_input_select;
		logic negative_input_select;
	} dcc_analog_t;

	// Result pin of one comparator
	typedef struct packed {
		logic value;
		logic drive;
	} dcc_pin_t;

endpackage

// File: rtl/dcc_channel.sv
`timescale 1ns/1ns
`default_nettype none

module dcc_channel (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Analog stage
	input wire logic raw_result,
	input wire logic enable,
	// Digital result
	output logic result,
	output logic change
);

	logic sync_a;
	logic sync_b;
	logic sync_c;
	logic next_result;

	// Three stages; the first feeds only the second
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sync_a <= 1'b0;
			sync_b <= 1'b0;
			sync_c <= 1'b0;
		end else begin
			sync_a <= raw_result;
			sync_b <= sync_a;
			sync_c <= sync_b;
		end
	end

	// A disabled stage reads low; a level counts once two stages agree
	always_comb begin
		next_result = result;
		if (!enable)
			next_result = 1'b0;
		else if (sync_b == sync_c)
			next_result = sync_c; // [R2]
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			result <= 1'b0;
			change <= 1'b0;
		end else begin
			result <= next_result;
			change <= next_result != result; // [R7]
		end
	end

endmodule // dcc_channel

`default_nettype wire

// File: rtl/dcc_top.sv
// Contract
// [R1] There are two comparators, each with its own control register of identical layout.
// [R2] A result is one when the chosen positive input exceeds the chosen negative input, readable and optionally driven to a pin.
// [R3] The positive input is one of two pins; the negative input is a pin or the internal reference.
// [R4] Positive select, negative select and pin drive enable give eight configurations per comparator.
// [R5] Software treats result and flag as unreliable for 10 us after enabling and keeps the interrupt off meanwhile.
// [R6] Software clears the change flag before setting the comparator interrupt enable.
// [R7] The change flag in the control register is set on every rising and falling result transition.
// [R8] The flag can always be polled; a request is raised only when the comparator enable and the global enable are set.
// [R9] Enabled comparators keep working in low-power modes and an enabled change raises the interrupt and wakes the processor.
// [R10] The service routine clears the change flag, since servicing does not clear it.
// [R11] A result pin used in power-down should be configured as push-pull by software.
// [R12] The change flag is bit 0 of each control register and is cleared by writing zero there.
// [R13] Writing 24h to the first register enables it with first positive pin, external reference pin and pin output.
// [R14] Reset clears both control registers, so both comparators are off, unrouted and unflagged.
`timescale 1ns/1ns
`default_nettype none

`include "dcc_params.svh"

module dcc_top (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Analog stages
	input wire logic [1:0] raw_result,
	output dcc_pkg::dcc_analog_t analog_one,
	output dcc_pkg::dcc_analog_t analog_two,
	// Result pins
	output dcc_pkg::dcc_pin_t pin_one,
	output dcc_pkg::dcc_pin_t pin_two,
	// Interrupts
	output logic cmp_irq_req,
	output logic wake_req,
	output logic evt_irq
);

	import dcc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Declarations

	dcc_ctrl_t ctrl [2];
	logic [1:0] result;
	logic [1:0] change;
	logic [1:0] pin_drive;
	logic [7:0] irq_en;
	logic [3:0] evt_status;
	logic [3:0] evt_mask;
	logic [3:0] evt_set;
	logic [1:0] settled;
	logic [1:0] settle_done;
	logic [7:0] settle_cnt [2];
	logic bus_req;
	logic bus_wr;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [31:0] next_rdata;
	logic [1:0] cmp_pending;
	logic next_cmp_irq;

	////////////////////////////////////////////////////////////////////////
	// Bus decode

	// Only the low byte carries register bits; other lanes are ignored
	assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign bus_wr = bus_req && wb_we_i && wb_sel_i[0];
	assign addr = {wb_adr_i[7:2], 2'b00};
	assign wdata = wb_dat_i[7:0];

	// Every access is answered one cycle after it is seen
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= bus_req;
	end

	////////////////////////////////////////////////////////////////////////
	// Comparator control registers

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_cmp
			logic hit;
			logic wr;

			assign hit = addr == (gi == 0 ? `DCC_OFS_CMP_ONE :
				`DCC_OFS_CMP_TWO);
			assign wr = bus_wr && hit;

			// Configuration bits; both registers share one layout
			always_ff @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n) begin
					ctrl[gi].reserved <= 2'b00;
					ctrl[gi].enable <=
						1'(`DCC_CTRL_RESET >> `DCC_CTRL_EN_BIT); // [R14]
					ctrl[gi].positive_input_select <= 1'b0;
					ctrl[gi].negative_input_select <= 1'b0;
					ctrl[gi].result_pin_drive_enable <= 1'b0;
				end else if (wr) begin // [R1]
					ctrl[gi].reserved <= 2'b00;
					ctrl[gi].enable <= wdata[`DCC_CTRL_EN_BIT]; // [R13]
					ctrl[gi].positive_input_select <=
						wdata[`DCC_CTRL_POS_BIT]; // [R4]
					ctrl[gi].negative_input_select <=
						wdata[`DCC_CTRL_NEG_BIT]; // [R4]
					ctrl[gi].result_pin_drive_enable <=
						wdata[`DCC_CTRL_PIN_BIT]; // [R4]
				end
			end

			// Result mirrors the synchronised analog level
			always_ff @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n)
					ctrl[gi].result <= 1'b0;
				else
					ctrl[gi].result <= result[gi]; // [R2]
			end

			// A transition in the clearing cycle still leaves the flag set
			always_ff @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n)
					ctrl[gi].result_change_flag <= 1'b0; // [R14]
				else if (change[gi])
					ctrl[gi].result_change_flag <= 1'b1; // [R7]
				else if (wr)
					ctrl[gi].result_change_flag <=
						wdata[`DCC_CTRL_FLAG_BIT]; // [R12]
			end

			// Pin drive follows enable and routing together
			always_ff @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n)
					pin_drive[gi] <= 1'b0;
				else if (wr)
					pin_drive[gi] <= wdata[`DCC_CTRL_EN_BIT] &&
						wdata[`DCC_CTRL_PIN_BIT]; // [R2]
			end

			// Synchroniser and change detect for this stage
			dcc_channel u_channel (
				.clk_sys(clk_sys),
				.rst_n(rst_n),
				.raw_result(raw_result[gi]),
				.enable(ctrl[gi].enable),
				.result(result[gi]),
				.change(change[gi])
			);

			// Settling time counted after each enable, for software to poll
			always_ff @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n) begin
					settle_cnt[gi] <= 8'h00;
					settled[gi] <= 1'b0;
					settle_done[gi] <= 1'b0;
				end else if (!ctrl[gi].enable) begin
					settle_cnt[gi] <= 8'h00;
					settled[gi] <= 1'b0;
					settle_done[gi] <= 1'b0;
				end else if (!settled[gi]) begin
					settle_cnt[gi] <= settle_cnt[gi] + 8'h01;
					settled[gi] <=
						settle_cnt[gi] == 8'(`DCC_SETTLE_CYC - 1); // [R5]
					settle_done[gi] <=
						settle_cnt[gi] == 8'(`DCC_SETTLE_CYC - 1);
				end else begin
					settle_done[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Analog steering and result pins

	// Positive: 0 first pin, 1 second pin; negative: 0 pin, 1 reference
	assign analog_one.enable = ctrl[0].enable;
	assign analog_one.positive_input_select =
		ctrl[0].positive_input_select; // [R3]
	assign analog_one.negative_input_select =
		ctrl[0].negative_input_select; // [R3]
	assign analog_two.enable = ctrl[1].enable;
	assign analog_two.positive_input_select =
		ctrl[1].positive_input_select; // [R3]
	assign analog_two.negative_input_select =
		ctrl[1].negative_input_select; // [R3]

	// Pin value is the synchronised result, so it lags the stage slightly
	assign pin_one.value = result[0];
	assign pin_one.drive = pin_drive[0];
	assign pin_two.value = result[1];
	assign pin_two.drive = pin_drive[1];

	////////////////////////////////////////////////////////////////////////
	// Interrupt enables

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			irq_en <= `DCC_IEN_RESET;
		else if (bus_wr && addr == `DCC_OFS_IRQ_EN)
			irq_en <= wdata & 8'h83;
	end

	// Request is gated, the flag itself is not, so polling always works
	always_comb begin
		cmp_pending[0] = ctrl[0].result_change_flag &&
			irq_en[`DCC_IEN_CMP_ONE_BIT];
		cmp_pending[1] = ctrl[1].result_change_flag &&
			irq_en[`DCC_IEN_CMP_TWO_BIT];
		next_cmp_irq = |cmp_pending && irq_en[`DCC_IEN_GLOBAL_BIT]; // [R8]
	end

	// Request stays high until software clears the flag or its enable bits
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			cmp_irq_req <= 1'b0;
		else
			cmp_irq_req <= next_cmp_irq; // [R10]
	end

	// The block needs only clk_sys; the same request wakes the core
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			wake_req <= 1'b0;
		else
			wake_req <= next_cmp_irq; // [R9]
	end

	////////////////////////////////////////////////////////////////////////
	// Event status and mask

	assign evt_set = {settle_done, change};

	// Write one to clear; a new event in the same cycle wins
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			evt_status <= `DCC_EVT_RESET;
		else if (bus_wr && addr == `DCC_OFS_EVT_STATUS)
			evt_status <= evt_set | (evt_status & ~wdata[3:0]);
		else
			evt_status <= evt_set | evt_status;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			evt_mask <= `DCC_EVT_RESET;
		else if (bus_wr && addr == `DCC_OFS_EVT_MASK)
			evt_mask <= wdata[3:0];
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			evt_irq <= 1'b0;
		else
			evt_irq <= |(evt_status & evt_mask);
	end

	////////////////////////////////////////////////////////////////////////
	// Read data

	// Unmapped offsets read zero and are still acknowledged
	always_comb begin
		next_rdata = 32'h0000_0000;
		case (addr)
			`DCC_OFS_CMP_ONE: next_rdata[7:0] = ctrl[0];
			`DCC_OFS_CMP_TWO: next_rdata[7:0] = ctrl[1];
			`DCC_OFS_IRQ_EN: next_rdata[7:0] = irq_en;
			`DCC_OFS_EVT_STATUS: next_rdata[3:0] = evt_status;
			`DCC_OFS_EVT_MASK: next_rdata[3:0] = evt_mask;
			`DCC_OFS_SETTLE: next_rdata[1:0] = settled;
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			wb_dat_o <= 32'h0000_0000;
		else if (bus_req && !wb_we_i)
			wb_dat_o <= next_rdata;
	end

endmodule // dcc_top

`default_nettype wire

// File: sim/dcc_analog_model.sv
`timescale 1ns/1ns
`default_nettype none

module dcc_analog_model #(
	parameter logic [7:0] REF_LEVEL = 8'h80
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Steering
	input wire dcc_pkg::dcc_analog_t analog_one,
	input wire dcc_pkg::dcc_analog_t analog_two,
	// Pin levels
	input wire logic [1:0][7:0] pos_a,
	input wire logic [1:0][7:0] pos_b,
	input wire logic [1:0][7:0] neg_pin,
	// Stage outputs
	output logic [1:0] raw_result
);
	import dcc_pkg::*;
	logic toggle;
	dcc_analog_t st [2];
	logic [7:0] p [2];
	logic [7:0] n [2];
	assign st[0] = analog_one;
	assign st[1] = analog_two;
	// A stage that is off shows no stable level
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			toggle <= 1'b0;
		end else begin
			toggle <= !toggle;
		end
	end
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			p[i] = st[i].positive_input_select ? pos_b[i] : pos_a[i];
			n[i] = st[i].negative_input_select ? REF_LEVEL : neg_pin[i];
			raw_result[i] = st[i].enable ? (p[i] > n[i]) : toggle;
		end
	end
endmodule // dcc_analog_model

`default_nettype wire

// File: sim/dcc_top_props.sv
`timescale 1ns/1ns
`default_nettype none

module dcc_top_props (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic wb_ack_o,
	// Stages and pins
	input wire logic [1:0] raw_result,
	input wire dcc_pkg::dcc_analog_t analog_one,
	input wire dcc_pkg::dcc_analog_t analog_two,
	input wire dcc_pkg::dcc_pin_t pin_one,
	input wire dcc_pkg::dcc_pin_t pin_two,
	// Interrupts
	input wire logic cmp_irq_req,
	input wire logic wake_req
);
	import dcc_pkg::*;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
		|=> wb_ack_o)
		else $error("request not answered next cycle");
	a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	a_wake_same: assert property (wake_req == cmp_irq_req)
		else $error("wake differs from irq");
	a_steer_write: assert property (
		!$stable(analog_one) || !$stable(analog_two)
		|-> wb_ack_o && wb_we_i)
		else $error("steering moved without write");
	a_drive_off: assert property (
		!analog_one.enable && $past(!analog_one.enable)
		|-> !pin_one.drive)
		else $error("pin driven while off");
	a_pin_high: assert property (
		(analog_one.enable && raw_result[0]) [*7]
		|=> pin_one.value)
		else $error("pin not high");
	a_pin_low: assert property ((!raw_result[1]) [*7] |=> !pin_two.value)
		else $error("pin not low");
	a_reset_quiet: assert property (
		disable iff (1'b0) !rst_n |-> analog_one == '0
		&& analog_two == '0 && pin_one == '0 && !cmp_irq_req)
		else $error("outputs active in reset");
endmodule // dcc_top_props

bind dcc_top dcc_top_props u_props (.clk_sys(clk_sys), .rst_n(rst_n),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_ack_o(wb_ack_o), .raw_result(raw_result), .analog_one(analog_one),
	.analog_two(analog_two), .pin_one(pin_one), .pin_two(pin_two),
	.cmp_irq_req(cmp_irq_req), .wake_req(wake_req));

`default_nettype wire

// File: sim/dcc_top_tb_top.sv
`timescale 1ns/1ns
`default_nettype none

module dcc_top_tb_top;
	import dcc_pkg::*;
	logic clk_sys = 0;
	logic rst_n;
	logic cyc = 0, stb = 0, we = 0, ack, irq, wake, evt;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h0, rdat;
	logic [1:0] raw;
	logic [1:0][7:0] pos_a = 16'h1010, pos_b = 16'h1010, neg_pin = 16'h4040;
	dcc_analog_t an1, an2;
	dcc_pin_t p1, p2;
	int error_cnt = 0;
	int tests_run = 0;
	dcc_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1),
		.wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .raw_result(raw),
		.analog_one(an1), .analog_two(an2), .pin_one(p1), .pin_two(p2),
		.cmp_irq_req(irq), .wake_req(wake), .evt_irq(evt));
	dcc_analog_model u_far (.clk_sys(clk_sys), .rst_n(rst_n),
		.analog_one(an1), .analog_two(an2), .pos_a(pos_a), .pos_b(pos_b),
		.neg_pin(neg_pin), .raw_result(raw));
	initial begin
		forever #20 clk_sys = ~clk_sys;
	end
	////////////////////////////////////////////////////////////////
	task automatic summarize();
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] s, e);
		tests_run++;
		if (s !== e) begin
			error_cnt++;
			$display("wrong value %s exp %h got %h", nm, e, s);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	// Request held until ack is seen at a rising edge; data taken there
	task automatic bus(input logic w, input logic [7:0] a, d,
		output logic [7:0] q);
		int n;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= {24'h0, d};
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (ack !== 1'b1) begin
			error_cnt++;
			summarize();
		end
		q = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic wr(input logic [7:0] a, d);
		logic [7:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, e);
		logic [7:0] q;
		bus(1'b0, a, 8'h00, q);
		chk($sformatf("reg %h", a), q, e);
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_reset();
		rd(8'h00, 8'h00);
		rd(8'h04, 8'h00);
		rd(8'h08, 8'h00);
		rd(8'h0c, 8'h00);
		wr(8'h20, 8'hff);
		rd(8'h20, 8'h00);
	endtask
	task automatic t_example();
		logic [7:0] q;
		wr(8'h00, 8'h24);
		chk("an1", {5'h0, an1}, 8'h04);
		rd(8'h00, 8'h24);
		pos_a <= 16'h1060;
		wt(6);
		rd(8'h00, 8'h27);
		chk("p1", {6'h0, p1}, 8'h03);
		chk("p1 drive", {7'h0, p1.drive}, 8'h01);
		bus(1'b0, 8'h00, 8'h00, q);
		wr(8'h00, q & 8'hfe);
		rd(8'h00, 8'h26);
		pos_a <= 16'h1010;
		wt(6);
		rd(8'h00, 8'h25);
		chk("p1", {6'h0, p1}, 8'h01);
	endtask
	task automatic t_config();
		for (logic [3:0] c = 0; c < 8; c++) begin
			wr(8'h04, 8'h20 | {3'h0, c[2:0], 2'h0});
			wt(2);
			chk("an2", {5'h0, an2}, {5'h00, 1'b1, c[2], c[1]});
			chk("p2", {7'h0, p2.drive}, {7'h0, c[0]});
		end
		pos_b <= 16'h9010;
		wt(6);
		rd(8'h04, 8'h3f);
	endtask
	// Interrupts are enabled only after settling and a flag clear
	task automatic t_irq();
		wt(250);
		rd(8'h14, 8'h03);
		wr(8'h00, 8'h24);
		wr(8'h08, 8'h81);
		wt(3);
		chk("irq", {7'h0, irq}, 8'h00);
		pos_a <= 16'h1060;
		wt(7);
		chk("irq", {7'h0, irq}, 8'h01);
		chk("wake", {7'h0, wake}, 8'h01);
		wr(8'h08, 8'h80);
		wt(3);
		chk("irq", {7'h0, irq}, 8'h00);
		wr(8'h08, 8'h01);
		wt(3);
		chk("irq", {7'h0, irq}, 8'h00);
		wr(8'h00, 8'h24);
		wr(8'h08, 8'h81);
		wt(3);
		chk("irq", {7'h0, irq}, 8'h00);
	endtask
	task automatic t_event();
		wr(8'h0c, 8'hff);
		wr(8'h10, 8'h01);
		wt(2);
		chk("evt", {7'h0, evt}, 8'h00);
		pos_a <= 16'h1010;
		wt(7);
		chk("evt", {7'h0, evt}, 8'h01);
		wr(8'h0c, 8'h01);
		wt(2);
		chk("evt", {7'h0, evt}, 8'h00);
		wt(260);
		rd(8'h14, 8'h03);
	endtask
	initial begin
		rst_n <= 1'b0;
		wt(16);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		t_reset();
		t_example();
		t_config();
		t_irq();
		t_event();
		summarize();
	end
endmodule // dcc_top_tb_top

`default_nettype wire
